// *** scb_pkg.sv ***
// Package for the shunt converter B calibration and overcurrent block
package scb_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_OFFSET_UPPER = 8'hC4;
  localparam logic [7:0] ADDR_OFFSET_LOWER = 8'hC5;
  localparam logic [7:0] ADDR_GAIN         = 8'hC6;
  localparam logic [7:0] ADDR_CONFIG       = 8'hC7;
  localparam logic [7:0] ADDR_STATUS       = 8'hF0;
  localparam logic [7:0] ADDR_FAST_RESULT  = 8'hF1;

  // ==========================================================
  // Field positions and reset values
  localparam int CFG_ENABLE_BIT  = 15;
  localparam int CFG_POL_BIT     = 14;
  localparam int CFG_SPARE_BIT   = 13;
  localparam int CFG_NUM_MSB     = 12;
  localparam int CFG_NUM_LSB     = 8;
  localparam int OFFSET_LOW_MSB  = 15;
  localparam int OFFSET_LOW_LSB  = 8;
  localparam int STAT_HIGH_BIT   = 1;
  localparam int STAT_LOW_BIT    = 0;

  localparam logic [15:0] RST_OFFSET_UPPER = 16'h0000;
  localparam logic [7:0]  RST_OFFSET_LOWER = 8'h00;
  localparam logic [15:0] RST_GAIN         = 16'h0000;
  localparam logic [4:0]  RST_DEGLITCH     = 5'h00;

  // Threshold codes that switch one side of the comparator off
  localparam logic [15:0] HIGH_DISABLE = 16'h7FFF;
  localparam logic [15:0] LOW_DISABLE  = 16'h8000;

  // ==========================================================
  // Fast filter and gain constants
  localparam int SINC_OSR   = 64;
  localparam int SINC_ORDER = 3;
  localparam int SINC_WIDTH = 20;
  localparam int FAST_WIDTH = 16;
  localparam int GAIN_SHIFT = 16;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } scb_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } scb_sample_t;

  typedef struct packed {
    logic level;
    logic outEnN;
  } scb_pin_t;

  // Deglitch code to number of consecutive fast results
  function automatic logic [7:0] scb_deglitch_count(input logic [4:0] code);
    logic [7:0] n;
    n = 8'h01;
    case (code)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
      5'h05, 5'h06, 5'h07, 5'h08, 5'h09: n = {3'h0, code} + 8'h01;
      5'h0A, 5'h0B, 5'h0C, 5'h0D,
      5'h0E, 5'h0F, 5'h10, 5'h11: n = {2'h0, code, 1'b0} - 8'h08;
      5'h12: n = 8'h1C;
      5'h13: n = 8'h20;
      5'h14: n = 8'h24;
      5'h15: n = 8'h28;
      5'h16: n = 8'h30;
      5'h17: n = 8'h38;
      5'h18: n = 8'h40;
      5'h19: n = 8'h48;
      5'h1A: n = 8'h50;
      5'h1B: n = 8'h58;
      5'h1C: n = 8'h60;
      5'h1D: n = 8'h68;
      5'h1E: n = 8'h70;
      default: n = 8'h80;
    endcase
    return n;
  endfunction : scb_deglitch_count

endpackage : scb_pkg

// *** scb_sinc3.sv ***
// Third-order sinc decimator feeding the overcurrent comparator
module scb_sinc3
  import scb_pkg::*;
#(
  parameter int OSR   = SINC_OSR,
  parameter int WIDTH = SINC_WIDTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  run,
  input  wire logic                  modBit,
  input  wire logic                  modValid,
  output logic [FAST_WIDTH-1:0]      fastData,
  output logic                       fastValid
);
  localparam int PH_BITS = $clog2(OSR);
  localparam int SHIFT   = WIDTH - FAST_WIDTH - 1;

  typedef struct packed {
    logic [SINC_ORDER-1:0][WIDTH-1:0] integ;
    logic [SINC_ORDER-1:0][WIDTH-1:0] combDly;
    logic [PH_BITS-1:0]               phase;
    logic [FAST_WIDTH-1:0]            data;
    logic                             valid;
  } scb_sinc_state_t;

  scb_sinc_state_t s;
  scb_sinc_state_t next_s;
  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] scaled;

  // ==========================================================
  // Integrate every modulator bit, comb once per OSR bits
  always_comb begin
    next_s = s;
    stage  = '0;
    scaled = '0;
    next_s.valid = 1'b0;
    if (!run) begin
      next_s = '0; // Filter held cleared so a restart never sees stale sums
    end else if (modValid) begin
      // Bit maps to +1 or -1; wrap-around in the integrators cancels in the combs
      next_s.integ[0] = s.integ[0] + (modBit ? WIDTH'(1) : {WIDTH{1'b1}});
      for (int k = 1; k < SINC_ORDER; k++) begin
        next_s.integ[k] = s.integ[k] + s.integ[k-1];
      end
      next_s.phase = s.phase + 1'b1;
      if (s.phase == PH_BITS'(OSR - 1)) begin
        stage = s.integ[SINC_ORDER-1];
        for (int k = 0; k < SINC_ORDER; k++) begin
          next_s.combDly[k] = stage;
          stage = stage - s.combDly[k];
        end
        scaled = WIDTH'($signed(stage) >>> SHIFT);
        // Full positive scale lands one code above the 16-bit range
        if ($signed(scaled) > $signed(WIDTH'(32767))) begin
          next_s.data = 16'h7FFF;
        end else begin
          next_s.data = scaled[FAST_WIDTH-1:0];
        end
        next_s.valid = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fastData  = s.data;
  assign fastValid = s.valid;

endmodule : scb_sinc3

// *** scb_overcurrent.sv ***
// Calibration, fast overcurrent comparator and fault pin for shunt converter B
// Contract
// - Offset correction is 24 bits, split across two registers
// - Offset step follows the 24-bit result LSB
// - Gain factor is one plus code over 65536
// - Comparator enable runs fast filter and comparator; the code also gates both on converterEnable
// - Start and stop never touch the fast path
// - Polarity bit picks fault level on the pin
// - Fault is any high or low event
// - Pin carries fault only when source selects it
// - Deglitch code sets consecutive results needed to trip
// - Fast path is sinc3 with OSR 64
// - Result inside thresholds restarts the deglitch count
// - Above high threshold raises high event; 7FFF disables
// - Below low threshold raises low event; 8000 disables
module scb_overcurrent
  import scb_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire scb_reg_req_t regReq,
  output logic [15:0]       regRdata,
  input  wire scb_sample_t  rawIn,
  input  wire logic         convStart,
  input  wire logic         convStop,
  input  wire logic         converterEnable,
  input  wire logic         modBit,
  input  wire logic         modValid,
  input  wire logic [15:0]  highThreshold,
  input  wire logic [15:0]  lowThreshold,
  input  wire logic         pinSourceSel,
  input  wire logic         pinFormat,
  output scb_sample_t       corrOut,
  output scb_pin_t          pinDrive,
  output logic              highEvent,
  output logic              lowEvent,
  output logic              faultActive
);

  typedef struct packed {
    logic [15:0]           offUpper;
    logic [7:0]            offLower;
    logic [15:0]           gain;
    logic                  cfgEnable;
    logic                  cfgPol;
    logic                  cfgSpare;
    logic [4:0]            cfgNum;
    logic [15:0]           rdata;
    logic                  running;
    scb_sample_t           corr;
    logic [7:0]            highCnt;
    logic [7:0]            lowCnt;
    logic                  highEvt;
    logic                  lowEvt;
    logic [FAST_WIDTH-1:0] lastFast;
    scb_pin_t              pin;
  } scb_state_t;

  scb_state_t s;
  scb_state_t next_s;

  logic [FAST_WIDTH-1:0] fastData;
  logic                  fastValid;
  logic                  active;
  logic [7:0]            target;
  logic                  overHigh;
  logic                  underLow;
  logic                  pinLevel;
  logic signed [24:0]    diff;
  logic signed [40:0]    prod;
  logic signed [25:0]    sum;

  // ==========================================================
  // Fast filter path
  // Comparator only meaningful while the converter itself runs
  assign active = s.cfgEnable & converterEnable;
  assign target = scb_deglitch_count(s.cfgNum);

  // Start and stop are not wired here, so the fast path keeps running
  scb_sinc3 #(
    .OSR   (SINC_OSR),
    .WIDTH (SINC_WIDTH)
  ) u_sinc (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .run       (active),
    .modBit    (modBit),
    .modValid  (modValid),
    .fastData  (fastData),
    .fastValid (fastValid)
  );

  // Threshold tests; the extreme codes switch a side off
  assign overHigh = (highThreshold != HIGH_DISABLE) &&
                    ($signed(fastData) > $signed(highThreshold));
  assign underLow = (lowThreshold != LOW_DISABLE) &&
                    ($signed(fastData) < $signed(lowThreshold));

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    diff   = '0;
    prod   = '0;
    sum    = '0;
    pinLevel = 1'b0;

    // Register writes
    if (regReq.wr) begin
      case (regReq.addr)
        ADDR_OFFSET_UPPER: next_s.offUpper = regReq.wdata;
        ADDR_OFFSET_LOWER: next_s.offLower = regReq.wdata[OFFSET_LOW_MSB:OFFSET_LOW_LSB];
        ADDR_GAIN:         next_s.gain = regReq.wdata;
        ADDR_CONFIG: begin
          next_s.cfgEnable = regReq.wdata[CFG_ENABLE_BIT];
          next_s.cfgPol    = regReq.wdata[CFG_POL_BIT];
          next_s.cfgSpare  = regReq.wdata[CFG_SPARE_BIT];
          next_s.cfgNum    = regReq.wdata[CFG_NUM_MSB:CFG_NUM_LSB];
        end
        default: ;
      endcase
    end

    // Read data stands for one cycle only; unmapped reads give zero
    next_s.rdata = '0;
    if (regReq.rd) begin
      case (regReq.addr)
        ADDR_OFFSET_UPPER: next_s.rdata = s.offUpper;
        ADDR_OFFSET_LOWER: next_s.rdata = {s.offLower, 8'h00};
        ADDR_GAIN:         next_s.rdata = s.gain;
        ADDR_CONFIG:       next_s.rdata = {s.cfgEnable, s.cfgPol, s.cfgSpare, s.cfgNum, 8'h00};
        ADDR_STATUS:       next_s.rdata = {14'h0000, s.highEvt, s.lowEvt};
        ADDR_FAST_RESULT:  next_s.rdata = s.lastFast;
        default:           next_s.rdata = '0;
      endcase
    end

    // Main path run state; stop wins when both arrive together
    if (!converterEnable || convStop) begin
      next_s.running = 1'b0;
    end else if (convStart) begin
      next_s.running = 1'b1;
    end

    // Offset then gain: y = (x - off) * (1 + g / 65536)
    next_s.corr.valid = 1'b0;
    if (rawIn.valid && s.running) begin
      diff = 25'($signed(rawIn.data)) - 25'($signed({s.offUpper, s.offLower}));
      // Both factors widened first so the product is never cut to the operand width
      prod = 41'(diff) * 41'($signed(s.gain));
      sum  = 26'(diff) + 26'(prod >>> GAIN_SHIFT);
      // Saturate so a large correction never wraps the sign
      if (sum > 26'sd8388607) begin
        next_s.corr.data = 24'h7FFFFF;
      end else if (sum < -26'sd8388608) begin
        next_s.corr.data = 24'h800000;
      end else begin
        next_s.corr.data = sum[23:0];
      end
      next_s.corr.valid = 1'b1;
    end

    // Deglitch counters, one per side, capped at the target
    if (!active) begin
      next_s.highCnt = '0;
      next_s.lowCnt  = '0;
      next_s.highEvt = 1'b0;
      next_s.lowEvt  = 1'b0;
    end else if (fastValid) begin
      next_s.lastFast = fastData;
      if (overHigh) begin
        next_s.highCnt = (s.highCnt >= target) ? target : s.highCnt + 8'h01;
        next_s.highEvt = (next_s.highCnt == target);
      end else begin
        next_s.highCnt = '0;
        next_s.highEvt = 1'b0;
      end
      if (underLow) begin
        next_s.lowCnt = (s.lowCnt >= target) ? target : s.lowCnt + 8'h01;
        next_s.lowEvt = (next_s.lowCnt == target);
      end else begin
        next_s.lowCnt = '0;
        next_s.lowEvt = 1'b0;
      end
    end

    // Pin drive; open-drain only pulls low and releases otherwise
    pinLevel = (s.highEvt | s.lowEvt) ? s.cfgPol : ~s.cfgPol;
    if (!pinSourceSel) begin
      next_s.pin.level  = 1'b0;
      next_s.pin.outEnN = 1'b1;
    end else if (pinFormat) begin
      next_s.pin.level  = 1'b0;
      next_s.pin.outEnN = pinLevel;
    end else begin
      next_s.pin.level  = pinLevel;
      next_s.pin.outEnN = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.pin.outEnN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign regRdata    = s.rdata;
  assign corrOut     = s.corr;
  assign pinDrive    = s.pin;
  assign highEvent   = s.highEvt;
  assign lowEvent    = s.lowEvt;
  assign faultActive = s.highEvt | s.lowEvt;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  lower_reserved_a : assert property (
    regReq.rd && regReq.addr == ADDR_OFFSET_LOWER |=> regRdata == {$past(s.offLower), 8'h00})
    else $error("offset lower read wrong");

  upper_write_a : assert property (
    regReq.wr && regReq.addr == ADDR_OFFSET_UPPER ##1
    regReq.rd && regReq.addr == ADDR_OFFSET_UPPER |=> regRdata == $past(regReq.wdata, 2))
    else $error("offset upper not stored");

  gain_unity_a : assert property (
    rawIn.valid && s.running && s.gain == 16'h0000 && s.offUpper == 16'h0000 && s.offLower == 8'h00
    |=> corrOut.valid && corrOut.data == $past(rawIn.data))
    else $error("unity correction altered data");

  disable_clear_a : assert property (
    !active |=> !highEvent && !lowEvent && s.highCnt == 8'h00 && s.lowCnt == 8'h00)
    else $error("disabled comparator kept state");

  trip_count_a : assert property (
    $rose(highEvent) |-> $past(fastValid) && $past(s.highCnt) == $past(target) - 8'h01)
    else $error("high event tripped at wrong count");

  inside_restart_a : assert property (
    active && fastValid && !overHigh && !underLow |=> s.highCnt == 8'h00 && s.lowCnt == 8'h00 && !faultActive)
    else $error("count not restarted inside thresholds");

  high_off_a : assert property (
    active && fastValid && highThreshold == HIGH_DISABLE |=> s.highCnt == 8'h00 && !highEvent)
    else $error("disabled high side counted");

  low_off_a : assert property (
    active && fastValid && lowThreshold == LOW_DISABLE |=> s.lowCnt == 8'h00 && !lowEvent)
    else $error("disabled low side counted");

  pin_level_a : assert property (
    pinSourceSel && !pinFormat |=> !pinDrive.outEnN &&
    pinDrive.level == ($past(faultActive) ? $past(s.cfgPol) : !$past(s.cfgPol)))
    else $error("fault pin level wrong");

  pin_release_a : assert property (
    !pinSourceSel [*2] |-> pinDrive.outEnN)
    else $error("pin driven without source select");

endmodule : scb_overcurrent

// *** scb_fault_monitor.sv ***
// Fault monitor model: the board side of the shared pin with its pull-up
module scb_fault_monitor
  import scb_pkg::*;
(
  input  wire scb_pin_t pinDrive,
  output logic          pinWire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Wire resolution
  // A released pin reads high through the pull-up, never the last driven value
  assign pinWire = pinDrive.outEnN ? 1'b1 : pinDrive.level;
endmodule : scb_fault_monitor

// *** scb_overcurrent_tb.sv ***
// Self-checking testbench for the shunt converter B calibration and overcurrent block
`define SCB_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errTotal++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module scb_overcurrent_tb
  import scb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic         ref_clk = 1'b0;
  logic         nrst = 1'b0;
  scb_reg_req_t regReq = '0;
  scb_sample_t  rawIn = '0;
  scb_sample_t  corrOut;
  scb_pin_t     pinDrive;
  logic [15:0]  regRdata;
  logic [15:0]  highThreshold = 16'h4000;
  logic [15:0]  lowThreshold = LOW_DISABLE;
  logic         convStart = 1'b0, convStop = 1'b0, converterEnable = 1'b1;
  logic         modBit = 1'b0, modValid = 1'b1, bitLevel = 1'b1, stopArm = 1'b0;
  logic         pinSourceSel = 1'b1, pinFormat = 1'b0;
  logic         highEvent, lowEvent, faultActive, pinWire;
  int           errTotal = 0, checked = 0;
  int           t0, t1, t2, n;
  logic [23:0]  off, x;
  logic [15:0]  g, d;
  logic [4:0]   rc;
  logic [15:0]  gainTbl [4] = '{16'h0000, 16'h7FFF, 16'hFFFF, 16'h8000};

  always #2.5 ref_clk = ~ref_clk;
  // Modulator stream and stop pulses launched on the rising edge
  always @(posedge ref_clk) begin
    modBit   <= bitLevel;
    convStop <= stopArm;
  end

  scb_overcurrent uut (.ref_clk(ref_clk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata),
    .rawIn(rawIn), .convStart(convStart), .convStop(convStop), .converterEnable(converterEnable),
    .modBit(modBit), .modValid(modValid), .highThreshold(highThreshold),
    .lowThreshold(lowThreshold), .pinSourceSel(pinSourceSel), .pinFormat(pinFormat),
    .corrOut(corrOut), .pinDrive(pinDrive), .highEvent(highEvent), .lowEvent(lowEvent),
    .faultActive(faultActive));
  scb_fault_monitor mon (.pinDrive(pinDrive), .pinWire(pinWire));

  // ==========================================================
  // Reference models
  // Consecutive fast results needed before a trip
  function automatic int dgModel(input int c);
    int tbl [14] = '{28, 32, 36, 40, 48, 56, 64, 72, 80, 88, 96, 104, 112, 128};
    if (c < 10) return c + 1;
    if (c < 18) return 2 * c - 8;
    return tbl[c - 18];
  endfunction : dgModel
  // Offset removed first, then gain of one plus code over 65536, saturated
  function automatic logic [23:0] corrModel(input logic [23:0] xs, input logic [23:0] o,
                                            input logic [15:0] gc);
    longint dv, y;
    dv = longint'($signed(xs)) - longint'($signed(o));
    y = dv + ((dv * longint'($signed(gc))) >>> 16);
    if (y > 64'sd8388607) y = 64'sd8388607;
    if (y < -64'sd8388608) y = -64'sd8388608;
    return y[23:0];
  endfunction : corrModel

  // ==========================================================
  // Bus tasks; strobes rise after one edge and fall at the sampling edge
  task automatic regWrite(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask : regWrite
  task automatic regCheck(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    @(negedge ref_clk);
    `SCB_CHK(regRdata, e)
  endtask : regCheck
  // Enable the comparator and count cycles until the high event rises
  task automatic tripTime(input logic [4:0] c, input bit stopMid, output int t);
    regWrite(ADDR_CONFIG, {3'b100, c, 8'h00});
    t = 0;
    @(negedge ref_clk);
    while (highEvent !== 1'b1 && t < 12000) begin
      stopArm = stopMid && (t == 40);
      @(negedge ref_clk);
      t++;
    end
  endtask : tripTime
  task automatic disableCheck;
    regWrite(ADDR_CONFIG, 16'h0000);
    @(posedge ref_clk);
    @(negedge ref_clk);
    `SCB_CHK({highEvent, lowEvent, faultActive}, 3'b000)
  endtask : disableCheck
  task automatic end_of_test;
    $display("checked=%0d errTotal=%0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Watchdog sized well above the longest trip sequence
  initial begin
    repeat (80000) @(posedge ref_clk);
    errTotal++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h5FFF));
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    regCheck(ADDR_OFFSET_UPPER, RST_OFFSET_UPPER);
    regCheck(ADDR_OFFSET_LOWER, 16'h0000);
    regCheck(ADDR_GAIN, RST_GAIN);
    regCheck(ADDR_CONFIG, 16'h0000);
    regCheck(8'h10, 16'h0000);
    // Readback with reserved low bytes reading zero
    d = 16'($urandom());
    regWrite(ADDR_OFFSET_LOWER, d);
    regCheck(ADDR_OFFSET_LOWER, d & 16'hFF00);
    regWrite(ADDR_CONFIG, d & 16'h7FFF);
    regCheck(ADDR_CONFIG, d & 16'h7F00);
    regWrite(ADDR_CONFIG, 16'h0000);
    // Main path correction across the gain anchors and random codes
    @(posedge ref_clk);
    convStart <= 1'b1;
    @(posedge ref_clk);
    convStart <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      off = 24'($urandom());
      x = 24'($urandom());
      g = (i < 4) ? gainTbl[i] : 16'($urandom());
      regWrite(ADDR_OFFSET_UPPER, off[23:8]);
      regWrite(ADDR_OFFSET_LOWER, {off[7:0], 8'h00});
      regWrite(ADDR_GAIN, g);
      regCheck(ADDR_GAIN, g);
      @(posedge ref_clk);
      rawIn <= '{valid: 1'b1, data: x};
      @(posedge ref_clk);
      rawIn.valid <= 1'b0;
      @(negedge ref_clk);
      `SCB_CHK(corrOut.valid, 1'b1)
      `SCB_CHK(corrOut.data, corrModel(x, off, g))
    end
    // Comparator off: full-scale input never trips and the filter stays idle
    repeat (300) @(posedge ref_clk);
    @(negedge ref_clk);
    `SCB_CHK(highEvent, 1'b0)
    regCheck(ADDR_FAST_RESULT, 16'h0000);
    // Trip timing: same run with a stop pulse, then the longest and a random count
    tripTime(5'h00, 1'b0, t0);
    disableCheck();
    tripTime(5'h00, 1'b1, t1);
    `SCB_CHK(t1, t0)
    disableCheck();
    tripTime(5'h1F, 1'b0, t2);
    `SCB_CHK(t2 - t0, (dgModel(31) - 1) * SINC_OSR)
    disableCheck();
    rc = 5'($urandom_range(1, 30));
    tripTime(rc, 1'b0, t2);
    `SCB_CHK(t2 - t0, (dgModel(int'(rc)) - 1) * SINC_OSR)
    `SCB_CHK(faultActive, 1'b1)
    regCheck(ADDR_STATUS, 16'h0002);
    // Pin under every polarity, format and source while the fault stands
    for (int k = 0; k < 8; k++) begin
      regWrite(ADDR_CONFIG, {2'b10 | 2'(k), 1'b0, rc, 8'h00});
      @(posedge ref_clk);
      pinFormat <= k[1];
      pinSourceSel <= k[2];
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      if (k[2]) `SCB_CHK(pinWire, k[0])
      else `SCB_CHK(pinDrive.outEnN, 1'b1)
    end
    // No fault: push-pull pin rests at the inactive level
    disableCheck();
    pinFormat <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    // Polarity 0 with no fault drives the inactive level, which is high
    `SCB_CHK(pinWire, 1'b1)
    // High side disabled by full-scale threshold
    highThreshold <= HIGH_DISABLE;
    regWrite(ADDR_CONFIG, 16'h8000);
    repeat (1000) @(posedge ref_clk);
    @(negedge ref_clk);
    `SCB_CHK(highEvent, 1'b0)
    // Low side trips, then falls once threshold 8000 switches the low side off
    bitLevel = 1'b0;
    lowThreshold <= 16'hC000;
    n = 0;
    while (lowEvent !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    `SCB_CHK(lowEvent, 1'b1)
    regCheck(ADDR_STATUS, 16'h0001);
    lowThreshold <= LOW_DISABLE;
    repeat (300) @(posedge ref_clk);
    @(negedge ref_clk);
    `SCB_CHK(lowEvent, 1'b0)
    end_of_test();
  end
endmodule : scb_overcurrent_tb
